//--- mst_pkg.sv
// package: constants and carrier types for the modem sync and tuning register bank
// assumes: one 10 MHz core clock, byte-wide register port addressed by printed offset
package mst_pkg;
	localparam int CLK_HZ = 10000000;
	localparam int FREQ_STEP_HZ = 7800;

	localparam logic [6:0] OFS_CORR_CTRL = 7'h47;
	localparam logic [6:0] OFS_FREQ_EST = 7'h48;
	localparam logic [6:0] OFS_SNIFF_TEST = 7'h5b;
	localparam logic [6:0] OFS_UNUSED = 7'h62;

	localparam logic [7:0] RST_CORR_CTRL = 8'h2e;
	localparam logic [7:0] RST_FREQ_EST = 8'h00;
	localparam logic [7:0] RST_SNIFF_TEST = 8'h08;

	// writable bits of the two mixed registers; the rest read as zero
	localparam logic [7:0] CORR_CTRL_MASK = 8'h3f;
	localparam logic [7:0] SNIFF_TEST_MASK = 8'h0f;

	localparam int SFD_REQ_BIT = 5;
	localparam int THR_MSB = 4;
	localparam int SNIFF_BIT = 2;
	localparam int PHASE_BIT = 1;

	localparam logic [3:0] ZERO_SYM = 4'h0;
	localparam logic [3:0] SFD_SYM_FIRST = 4'h7;
	localparam logic [3:0] SFD_SYM_SECOND = 4'ha;

	localparam int NUM_TUNE = 23;
	// index 0 is the lowest tuning offset
	localparam logic [NUM_TUNE-1:0][6:0] TUNE_OFS = {
		7'h7e, 7'h7c, 7'h7a, 7'h61, 7'h60, 7'h5f, 7'h5e, 7'h5d,
		7'h5c, 7'h5a, 7'h58, 7'h57, 7'h56, 7'h55, 7'h54, 7'h53,
		7'h52, 7'h51, 7'h50, 7'h4f, 7'h4e, 7'h4c, 7'h4a};
	localparam logic [NUM_TUNE-1:0][7:0] TUNE_RST = {
		8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h05, 8'h05, 8'h0a, 8'h66, 8'h2e, 8'h00, 8'h0e,
		8'h5f, 8'h2a, 8'h20, 8'h29, 8'h24, 8'h55, 8'h29};

	typedef enum logic [1:0] {SEARCH, SFD_WAIT, LOCKED} mst_sync_t;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mst_bus_t;

	typedef struct packed {
		logic valid;
		logic [3:0] value;
		logic [7:0] corr;
	} mst_sym_t;

	typedef struct packed {
		logic valid;
		logic [7:0] estimate;
	} mst_freq_t;

	typedef struct packed {
		logic strobe;
		logic tx_active;
		logic rx_bit;
		logic tx_bit;
	} mst_sniff_t;

	typedef struct packed {
		logic hit;
		logic [4:0] idx;
	} mst_hit_t;

	typedef struct packed {
		logic [7:0] corr_ctrl;
		logic [7:0] freq;
		logic [7:0] sniff_test;
		logic [NUM_TUNE-1:0][7:0] tune;
		logic [7:0] rdata;
		mst_sync_t sync;
		logic [1:0] zero_cnt;
		logic zero_above;
		logic sync_pulse;
		logic locked;
		logic sniff_clk;
		logic sniff_data;
		logic phase_rev;
	} mst_state_t;
endpackage

//--- mst_regs.sv
// modem correlation/sync control, frequency offset estimate, sniffer/phase test bits
// and the tuning/test register map; assumes demodulator inputs share CORE_CLK
`timescale 1ns/100ps

module mst_regs (
	input wire logic CORE_CLK, // 10 MHz core clock
	input wire logic RESET_N, // asynchronous reset, active low
	input wire mst_pkg::mst_bus_t BUS, // register port request
	input wire logic DEMOD_EN, // demodulator enabled
	input wire logic FRAME_END, // received frame finished, pulse
	input wire logic AVG_MODE, // offset averaging setting
	input wire logic [1:0] ZERO_COUNT, // zero-symbol count setting
	input wire mst_pkg::mst_sym_t SYM, // decoded symbol with correlation
	input wire mst_pkg::mst_freq_t FREQ_IN, // raw offset estimate
	input wire mst_pkg::mst_sniff_t SNIFF_IN, // data to observe
	output logic [7:0] RDATA, // read data, cycle after read strobe
	output logic SYNC_FOUND, // sfd accepted, pulse
	output logic SYNC_LOCKED, // inside a received frame
	output logic GPIO_SNIFF_CLK, // sniffer bit strobe
	output logic GPIO_SNIFF_DATA, // sniffer bit
	output logic PHASE_REVERSE, // reversed-phase modulation
	output logic [mst_pkg::NUM_TUNE-1:0][7:0] TUNE_REGS // tuning register contents
);
	localparam mst_pkg::mst_state_t ST_RST = '{
		corr_ctrl: mst_pkg::RST_CORR_CTRL,
		freq: mst_pkg::RST_FREQ_EST,
		sniff_test: mst_pkg::RST_SNIFF_TEST,
		tune: mst_pkg::TUNE_RST,
		rdata: 8'h00,
		sync: mst_pkg::SEARCH,
		zero_cnt: 2'h0,
		zero_above: 1'b0,
		sync_pulse: 1'b0,
		locked: 1'b0,
		sniff_clk: 1'b0,
		sniff_data: 1'b0,
		phase_rev: 1'b0
	};

	logic [1:0] rst_q;
	logic rst_n;
	mst_pkg::mst_state_t st;
	mst_pkg::mst_state_t next_st;
	mst_pkg::mst_hit_t hit;
	logic above;
	logic strict;
	logic [1:0] need;

	function automatic mst_pkg::mst_hit_t tune_find(input logic [6:0] a);
		mst_pkg::mst_hit_t h;
		h.hit = 1'b0;
		h.idx = 5'h00;
		for (int i = 0; i < mst_pkg::NUM_TUNE; i++) begin
			if (a == mst_pkg::TUNE_OFS[i]) begin
				h.hit = 1'b1;
				h.idx = i[4:0];
			end
		end
		return h;
	endfunction

	// reset release through two flops
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	assign hit = tune_find(BUS.addr);
	assign above = SYM.corr > {3'h0, st.corr_ctrl[mst_pkg::THR_MSB:0]};
	assign strict = st.corr_ctrl[mst_pkg::SFD_REQ_BIT];
	// reserved code 00 behaves as one zero symbol
	assign need = (ZERO_COUNT == 2'h0) ? 2'h1 : ZERO_COUNT;

	always_comb begin
		next_st = st;
		next_st.rdata = 8'h00;
		next_st.sync_pulse = 1'b0;

		if (BUS.wr) begin
			if (BUS.addr == mst_pkg::OFS_CORR_CTRL)
				next_st.corr_ctrl = BUS.wdata & mst_pkg::CORR_CTRL_MASK;
			else if (BUS.addr == mst_pkg::OFS_SNIFF_TEST)
				next_st.sniff_test = BUS.wdata & mst_pkg::SNIFF_TEST_MASK;
			else if (hit.hit)
				next_st.tune[hit.idx] = BUS.wdata;
			// estimate and unused slot ignore writes
		end

		if (BUS.rd) begin
			if (BUS.addr == mst_pkg::OFS_CORR_CTRL)
				next_st.rdata = st.corr_ctrl & mst_pkg::CORR_CTRL_MASK;
			else if (BUS.addr == mst_pkg::OFS_FREQ_EST)
				next_st.rdata = st.freq;
			else if (BUS.addr == mst_pkg::OFS_SNIFF_TEST)
				next_st.rdata = st.sniff_test & mst_pkg::SNIFF_TEST_MASK;
			else if (hit.hit)
				next_st.rdata = st.tune[hit.idx];
		end

		// sync search
		if (!DEMOD_EN) begin
			next_st.sync = mst_pkg::SEARCH;
			next_st.zero_cnt = 2'h0;
			next_st.zero_above = 1'b0;
		end else begin
			unique case (st.sync)
				mst_pkg::SEARCH: begin
					if (SYM.valid) begin
						if (SYM.value == mst_pkg::ZERO_SYM) begin
							if (st.zero_cnt != 2'h3)
								next_st.zero_cnt = st.zero_cnt + 2'h1;
							// one zero above threshold is enough
							next_st.zero_above = st.zero_above | above;
						end else begin
							next_st.zero_cnt = 2'h0;
							next_st.zero_above = 1'b0;
							if (SYM.value == mst_pkg::SFD_SYM_FIRST &&
									st.zero_cnt >= need && st.zero_above &&
									(!strict || above))
								next_st.sync = mst_pkg::SFD_WAIT;
						end
					end
				end
				mst_pkg::SFD_WAIT: begin
					if (SYM.valid) begin
						if (SYM.value == mst_pkg::SFD_SYM_SECOND &&
								(!strict || above)) begin
							next_st.sync = mst_pkg::LOCKED;
							next_st.sync_pulse = 1'b1;
						end else
							next_st.sync = mst_pkg::SEARCH;
					end
				end
				mst_pkg::LOCKED: begin
					if (FRAME_END)
						next_st.sync = mst_pkg::SEARCH;
				end
			endcase
		end
		next_st.locked = (next_st.sync == mst_pkg::LOCKED);

		// offset estimate, while the demodulator is enabled: tracks always, or only until sync
		if (DEMOD_EN && FREQ_IN.valid && (AVG_MODE || st.sync != mst_pkg::LOCKED))
			next_st.freq = FREQ_IN.estimate;

		// sniffer on gpio, quiet when disabled
		if (st.sniff_test[mst_pkg::SNIFF_BIT]) begin
			next_st.sniff_clk = SNIFF_IN.strobe;
			next_st.sniff_data = SNIFF_IN.tx_active ? SNIFF_IN.tx_bit : SNIFF_IN.rx_bit;
		end else begin
			next_st.sniff_clk = 1'b0;
			next_st.sniff_data = 1'b0;
		end

		next_st.phase_rev = next_st.sniff_test[mst_pkg::PHASE_BIT];
	end

	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n)
			st <= ST_RST;
		else
			st <= next_st;
	end

	assign RDATA = st.rdata;
	assign SYNC_FOUND = st.sync_pulse;
	assign SYNC_LOCKED = st.locked;
	assign GPIO_SNIFF_CLK = st.sniff_clk;
	assign GPIO_SNIFF_DATA = st.sniff_data;
	assign PHASE_REVERSE = st.phase_rev;
	assign TUNE_REGS = st.tune;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!rst_n);

	sfd_accept_a: assert property (
		st.sync == mst_pkg::SFD_WAIT && DEMOD_EN && SYM.valid &&
		SYM.value == mst_pkg::SFD_SYM_SECOND && (!strict || above)
		|=> SYNC_FOUND ##1 !SYNC_FOUND && SYNC_LOCKED)
		else $error("sfd not accepted");

	sfd_strict_a: assert property (
		st.sync == mst_pkg::SFD_WAIT && SYM.valid && strict && !above
		|=> !SYNC_FOUND && st.sync == mst_pkg::SEARCH)
		else $error("strict sfd accepted below threshold");

	thr_gate_a: assert property (
		$rose(st.zero_above) |-> $past(above) && $past(SYM.value) == mst_pkg::ZERO_SYM)
		else $error("zero marked above threshold wrongly");

	zero_need_a: assert property (
		st.sync == mst_pkg::SEARCH && SYM.valid && st.zero_cnt < need
		|=> st.sync == mst_pkg::SEARCH)
		else $error("sfd search left with too few zeros");

	freq_read_a: assert property (
		BUS.rd && BUS.addr == mst_pkg::OFS_FREQ_EST |=> RDATA == $past(st.freq))
		else $error("offset estimate read wrong");

	freq_freeze_a: assert property (
		st.sync == mst_pkg::LOCKED && !AVG_MODE && SYNC_LOCKED |=> $stable(st.freq))
		else $error("estimate moved during frame");

	freq_track_a: assert property (
		AVG_MODE && DEMOD_EN && FREQ_IN.valid |=> st.freq == $past(FREQ_IN.estimate))
		else $error("estimate not tracking");

	sniff_gate_a: assert property (
		!st.sniff_test[mst_pkg::SNIFF_BIT] |=> !GPIO_SNIFF_CLK && !GPIO_SNIFF_DATA)
		else $error("sniffer active while disabled");

	phase_write_a: assert property (
		BUS.wr && BUS.addr == mst_pkg::OFS_SNIFF_TEST
		|=> PHASE_REVERSE == $past(BUS.wdata[mst_pkg::PHASE_BIT]))
		else $error("phase bit not applied");

	rsvd_read_a: assert property (
		BUS.rd && (BUS.addr == mst_pkg::OFS_UNUSED || BUS.addr == mst_pkg::OFS_CORR_CTRL)
		|=> RDATA[7:6] == 2'h0 ##1 RDATA == 8'h00 || $past(BUS.rd))
		else $error("reserved bits read nonzero");

	rsvd_unused_a: assert property (
		BUS.rd && BUS.addr == mst_pkg::OFS_UNUSED
		|=> RDATA == 8'h00)
		else $error("unused slot read nonzero");

	rsvd_sniff_a: assert property (
		BUS.rd && BUS.addr == mst_pkg::OFS_SNIFF_TEST
		|=> RDATA[7:4] == 4'h0)
		else $error("sniffer register upper bits read nonzero");

	corr_store_a: assert property (
		BUS.wr && BUS.addr == mst_pkg::OFS_CORR_CTRL
		|=> st.corr_ctrl == ($past(BUS.wdata) & mst_pkg::CORR_CTRL_MASK))
		else $error("correlation control write wrong");

	sniff_store_a: assert property (
		BUS.wr && BUS.addr == mst_pkg::OFS_SNIFF_TEST
		|=> st.sniff_test == ($past(BUS.wdata) & mst_pkg::SNIFF_TEST_MASK))
		else $error("sniffer register write wrong");

	corr_upper_a: assert property (
		st.corr_ctrl[7:6] == 2'h0)
		else $error("correlation control reserved bits set");

	sniff_upper_a: assert property (
		st.sniff_test[7:4] == 4'h0)
		else $error("sniffer register reserved bits set");

	unused_write_a: assert property (
		BUS.wr && BUS.addr == mst_pkg::OFS_UNUSED
		|=> $stable(st.corr_ctrl) && $stable(st.sniff_test) && $stable(st.tune))
		else $error("unused slot write changed a register");

	freq_nowrite_a: assert property (
		BUS.wr && BUS.addr == mst_pkg::OFS_FREQ_EST && !FREQ_IN.valid
		|=> $stable(st.freq))
		else $error("offset estimate taken from a write");

	tune_store_a: assert property (
		BUS.wr && hit.hit
		|=> TUNE_REGS[$past(hit.idx)] == $past(BUS.wdata))
		else $error("tuning register write wrong");

	rdata_idle_a: assert property (
		!BUS.rd |=> RDATA == 8'h00)
		else $error("read data outside read cycle");

	corr_read_a: assert property (
		BUS.rd && BUS.addr == mst_pkg::OFS_CORR_CTRL
		|=> RDATA == $past(st.corr_ctrl))
		else $error("correlation control read wrong");

	sniff_read_a: assert property (
		BUS.rd && BUS.addr == mst_pkg::OFS_SNIFF_TEST
		|=> RDATA == $past(st.sniff_test))
		else $error("sniffer register read wrong");

	tune_read_a: assert property (
		BUS.rd && hit.hit
		|=> RDATA == $past(st.tune[hit.idx]))
		else $error("tuning register read wrong");

	sfd_start_a: assert property (
		st.sync == mst_pkg::SEARCH && DEMOD_EN && SYM.valid &&
		SYM.value == mst_pkg::SFD_SYM_FIRST && st.zero_cnt >= need &&
		st.zero_above && (!strict || above)
		|=> st.sync == mst_pkg::SFD_WAIT)
		else $error("valid first sfd symbol not taken");

	sfd_first_a: assert property (
		st.sync == mst_pkg::SEARCH && SYM.valid && SYM.value == mst_pkg::SFD_SYM_FIRST &&
		strict && !above
		|=> st.sync == mst_pkg::SEARCH)
		else $error("strict first sfd symbol accepted below threshold");

	sfd_loose_a: assert property (
		st.sync == mst_pkg::SFD_WAIT && DEMOD_EN && SYM.valid &&
		SYM.value == mst_pkg::SFD_SYM_SECOND && !strict
		|=> SYNC_FOUND)
		else $error("sfd refused with threshold check off");

	sfd_drop_a: assert property (
		st.sync == mst_pkg::SFD_WAIT && DEMOD_EN && SYM.valid &&
		SYM.value != mst_pkg::SFD_SYM_SECOND
		|=> st.sync == mst_pkg::SEARCH && !SYNC_FOUND)
		else $error("broken sfd accepted");

	found_pulse_a: assert property (
		SYNC_FOUND |=> !SYNC_FOUND)
		else $error("sfd pulse longer than one cycle");

	found_lock_a: assert property (
		SYNC_FOUND |-> SYNC_LOCKED)
		else $error("sfd pulse without lock");

	lock_entry_a: assert property (
		$rose(SYNC_LOCKED) |-> SYNC_FOUND && $past(st.sync) == mst_pkg::SFD_WAIT)
		else $error("lock entered without sfd");

	thr_none_a: assert property (
		st.sync == mst_pkg::SEARCH && SYM.valid && SYM.value == mst_pkg::SFD_SYM_FIRST &&
		!st.zero_above
		|=> st.sync == mst_pkg::SEARCH)
		else $error("sfd search began with no zero above threshold");

	zero_clear_a: assert property (
		st.sync == mst_pkg::SEARCH && DEMOD_EN && SYM.valid &&
		SYM.value != mst_pkg::ZERO_SYM
		|=> st.zero_cnt == 2'h0 && !st.zero_above)
		else $error("zero count kept across other symbol");

	zero_sat_a: assert property (
		st.zero_cnt == 2'h3 |=> st.zero_cnt == 2'h3 || st.zero_cnt == 2'h0)
		else $error("zero count wrapped");

	freq_search_a: assert property (
		!AVG_MODE && DEMOD_EN && FREQ_IN.valid && st.sync != mst_pkg::LOCKED
		|=> st.freq == $past(FREQ_IN.estimate))
		else $error("estimate not updated before sync");

	frame_end_a: assert property (
		st.sync == mst_pkg::LOCKED && FRAME_END |=> !SYNC_LOCKED)
		else $error("lock held after frame end");

	demod_hold_a: assert property (
		!DEMOD_EN |=> $stable(st.freq))
		else $error("estimate moved with demodulator off");

	demod_search_a: assert property (
		!DEMOD_EN |=> st.sync == mst_pkg::SEARCH && st.zero_cnt == 2'h0 && !SYNC_LOCKED)
		else $error("sync state kept with demodulator off");

	sniff_clk_a: assert property (
		st.sniff_test[mst_pkg::SNIFF_BIT] |=> GPIO_SNIFF_CLK == $past(SNIFF_IN.strobe))
		else $error("sniffer strobe not passed");

	sniff_data_a: assert property (
		st.sniff_test[mst_pkg::SNIFF_BIT] && SNIFF_IN.tx_active
		|=> GPIO_SNIFF_DATA == $past(SNIFF_IN.tx_bit))
		else $error("sniffer transmit bit not passed");

	sniff_rx_a: assert property (
		st.sniff_test[mst_pkg::SNIFF_BIT] && !SNIFF_IN.tx_active
		|=> GPIO_SNIFF_DATA == $past(SNIFF_IN.rx_bit))
		else $error("sniffer receive bit not passed");

	phase_track_a: assert property (
		PHASE_REVERSE == st.sniff_test[mst_pkg::PHASE_BIT])
		else $error("phase output differs from its bit");
endmodule

//--- tb_mst_regs.sv
// testbench for the modem sync and tuning register bank: register port, sync, estimate, sniffer
// assumes the mst_pkg package and the mst_regs module are compiled first
`timescale 1ns/100ps

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
	$display("ERROR %0t got %h exp %h", $time, (a), (e)); end end

module tb_mst_regs;
	logic CORE_CLK = 1'b0;
	logic RESET_N = 1'b0;
	mst_pkg::mst_bus_t BUS = '0;
	logic DEMOD_EN = 1'b1;
	logic FRAME_END = 1'b0;
	logic AVG_MODE = 1'b0;
	logic [1:0] ZERO_COUNT = 2'h1;
	mst_pkg::mst_sym_t SYM = '0;
	mst_pkg::mst_freq_t FREQ_IN = '0;
	mst_pkg::mst_sniff_t SNIFF_IN = '0;
	logic [7:0] RDATA;
	logic SYNC_FOUND;
	logic SYNC_LOCKED;
	logic GPIO_SNIFF_CLK;
	logic GPIO_SNIFF_DATA;
	logic PHASE_REVERSE;
	logic [mst_pkg::NUM_TUNE-1:0][7:0] TUNE_REGS;
	int bad_count = 0;
	int check_count = 0;

	mst_regs mst_regs_inst (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .BUS(BUS),
		.DEMOD_EN(DEMOD_EN), .FRAME_END(FRAME_END), .AVG_MODE(AVG_MODE),
		.ZERO_COUNT(ZERO_COUNT), .SYM(SYM), .FREQ_IN(FREQ_IN), .SNIFF_IN(SNIFF_IN),
		.RDATA(RDATA), .SYNC_FOUND(SYNC_FOUND), .SYNC_LOCKED(SYNC_LOCKED),
		.GPIO_SNIFF_CLK(GPIO_SNIFF_CLK), .GPIO_SNIFF_DATA(GPIO_SNIFF_DATA),
		.PHASE_REVERSE(PHASE_REVERSE), .TUNE_REGS(TUNE_REGS));

	initial begin
		forever #50 CORE_CLK = ~CORE_CLK;
	end

	task conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge CORE_CLK) BUS <= {a, d, 2'b10};
		@(posedge CORE_CLK) BUS <= '0;
	endtask

	// read data is sampled just after the edge that follows the strobe cycle
	task rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge CORE_CLK) BUS <= {a, 8'h00, 2'b01};
		@(posedge CORE_CLK) BUS <= '0;
		#1 `CHK(RDATA, e)
	endtask

	task sym(input logic [3:0] v, input logic [7:0] c);
		@(posedge CORE_CLK) SYM <= {1'b1, v, c};
		@(posedge CORE_CLK) SYM <= '0;
	endtask

	task sfd(input int nz, input logic [7:0] cz, c7, ca, input logic e);
		repeat (nz) sym(mst_pkg::ZERO_SYM, cz);
		sym(mst_pkg::SFD_SYM_FIRST, c7);
		sym(mst_pkg::SFD_SYM_SECOND, ca);
		#1 `CHK(SYNC_FOUND, e)
		`CHK(SYNC_LOCKED, e)
		@(posedge CORE_CLK) #1 `CHK(SYNC_LOCKED, e)
		`CHK(SYNC_FOUND, 1'b0)
	endtask

	task fe();
		@(posedge CORE_CLK) FRAME_END <= 1'b1;
		@(posedge CORE_CLK) FRAME_END <= 1'b0;
		#1 `CHK(SYNC_LOCKED, 1'b0)
	endtask

	task fq(input logic [7:0] v);
		@(posedge CORE_CLK) FREQ_IN <= {1'b1, v};
		@(posedge CORE_CLK) FREQ_IN <= '0;
	endtask

	initial begin
		repeat (20000) @(posedge CORE_CLK);
		bad_count++;
		$display("ERROR %0t run did not finish", $time);
		conclude();
	end

	initial begin
		repeat (20) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		rd(mst_pkg::OFS_CORR_CTRL, 8'h2e);
		rd(mst_pkg::OFS_FREQ_EST, 8'h00);
		rd(mst_pkg::OFS_SNIFF_TEST, 8'h08);
		rd(mst_pkg::OFS_UNUSED, 8'h00);
		for (int i = 0; i < mst_pkg::NUM_TUNE; i++) begin
			rd(mst_pkg::TUNE_OFS[i], mst_pkg::TUNE_RST[i]);
			`CHK(TUNE_REGS[i], mst_pkg::TUNE_RST[i])
		end
		wr(7'h4a, 8'h5a);
		rd(7'h4a, 8'h5a);
		`CHK(TUNE_REGS[0], 8'h5a)
		wr(mst_pkg::OFS_CORR_CTRL, 8'hff);
		rd(mst_pkg::OFS_CORR_CTRL, 8'h3f);
		wr(mst_pkg::OFS_FREQ_EST, 8'h77);
		rd(mst_pkg::OFS_FREQ_EST, 8'h00);
		wr(mst_pkg::OFS_UNUSED, 8'hff);
		rd(mst_pkg::OFS_UNUSED, 8'h00);
		rd(7'h70, 8'h00);
		wr(mst_pkg::OFS_SNIFF_TEST, 8'hfe);
		rd(mst_pkg::OFS_SNIFF_TEST, 8'h0e);
		#1 `CHK(PHASE_REVERSE, 1'b1)
		$display("register test done");

		@(posedge CORE_CLK) SNIFF_IN <= 4'hd;
		@(posedge CORE_CLK) SNIFF_IN <= 4'h0;
		#1 `CHK({GPIO_SNIFF_CLK, GPIO_SNIFF_DATA}, 2'b11)
		@(posedge CORE_CLK) SNIFF_IN <= 4'ha;
		@(posedge CORE_CLK) SNIFF_IN <= 4'h0;
		#1 `CHK({GPIO_SNIFF_CLK, GPIO_SNIFF_DATA}, 2'b11)
		wr(mst_pkg::OFS_SNIFF_TEST, 8'h08);
		@(posedge CORE_CLK) SNIFF_IN <= 4'hd;
		@(posedge CORE_CLK) SNIFF_IN <= 4'h0;
		#1 `CHK({GPIO_SNIFF_CLK, GPIO_SNIFF_DATA, PHASE_REVERSE}, 3'b000)
		$display("sniffer test done");

		wr(mst_pkg::OFS_CORR_CTRL, 8'h14);
		sfd(1, 8'h15, 8'h00, 8'h00, 1'b1);
		fe();
		sfd(1, 8'h14, 8'hff, 8'hff, 1'b0);
		wr(mst_pkg::OFS_CORR_CTRL, 8'h34);
		sfd(1, 8'h15, 8'h00, 8'hff, 1'b0);
		sfd(1, 8'h15, 8'h15, 8'h00, 1'b0);
		sfd(1, 8'h15, 8'h15, 8'h15, 1'b1);
		fe();
		@(posedge CORE_CLK) ZERO_COUNT <= 2'h2;
		sfd(1, 8'h15, 8'h15, 8'h15, 1'b0);
		sfd(2, 8'h15, 8'h15, 8'h15, 1'b1);
		fe();
		@(posedge CORE_CLK) ZERO_COUNT <= 2'h3;
		sfd(2, 8'h15, 8'h15, 8'h15, 1'b0);
		sfd(3, 8'h15, 8'h15, 8'h15, 1'b1);
		fe();
		@(posedge CORE_CLK) ZERO_COUNT <= 2'h0;
		sfd(1, 8'h15, 8'h15, 8'h15, 1'b1);
		fe();
		@(posedge CORE_CLK) ZERO_COUNT <= 2'h1;
		$display("sync test done");

		fq(8'hf3);
		rd(mst_pkg::OFS_FREQ_EST, 8'hf3);
		sfd(1, 8'h15, 8'h15, 8'h15, 1'b1);
		fq(8'h05);
		rd(mst_pkg::OFS_FREQ_EST, 8'hf3);
		@(posedge CORE_CLK) AVG_MODE <= 1'b1;
		fq(8'h05);
		rd(mst_pkg::OFS_FREQ_EST, 8'h05);
		@(posedge CORE_CLK) AVG_MODE <= 1'b0;
		fe();
		fq(8'h80);
		rd(mst_pkg::OFS_FREQ_EST, 8'h80);
		sfd(1, 8'h15, 8'h15, 8'h15, 1'b1);
		@(posedge CORE_CLK) DEMOD_EN <= 1'b0;
		AVG_MODE <= 1'b1;
		@(posedge CORE_CLK) #1 `CHK(SYNC_LOCKED, 1'b0)
		fq(8'h33);
		rd(mst_pkg::OFS_FREQ_EST, 8'h80);
		@(posedge CORE_CLK) DEMOD_EN <= 1'b1;
		AVG_MODE <= 1'b0;
		$display("estimate test done");
		conclude();
	end
endmodule
